// ---- shared/mcsa_cfg.svh ----
// Purpose: constants of the motion command state arbiter
// Assumes: byte addresses on the register bus, 32-bit words
// Notes:   definitions only
`ifndef MCSA_CFG_SVH
`define MCSA_CFG_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MCSA_OFF_CTRL    5'h00
`define MCSA_OFF_SEC_POS 5'h04
`define MCSA_OFF_CMD     5'h08
`define MCSA_OFF_STATUS  5'h0c
`define MCSA_OFF_TARGET  5'h10
`define MCSA_OFF_ACTUAL  5'h14
`define MCSA_OFF_PARAM   5'h18
// ----------------------------------------
// field positions
// ----------------------------------------
`define MCSA_F_SEC_EN    0
`define MCSA_F_CODE      3:0
`define MCSA_F_DATA      31:16
`define MCSA_F_SHORT     26:16
`define MCSA_F_POS       15:0
`define MCSA_F_STATE     3:0
`define MCSA_F_SLEEP     4
// ----------------------------------------
// command codes
// ----------------------------------------
`define MCSA_CMD_LOAD    4'h1
`define MCSA_CMD_CLEAR   4'h2
`define MCSA_CMD_SET     4'h3
`define MCSA_CMD_SET_SH  4'h4
`define MCSA_CMD_GOSEC   4'h5
`define MCSA_CMD_TWO     4'h6
`define MCSA_CMD_DECEL   4'h7
`define MCSA_CMD_SLEEP   4'h8
// ----------------------------------------
// reset values and the one-step increment
// ----------------------------------------
`define MCSA_POS_RST     16'h0000
`define MCSA_PAR_RST     16'h0000
`define MCSA_WORD_ZERO   32'h0000_0000
`define MCSA_POS_ONE     16'h0001
`endif

// ---- shared/mcsa_pkg.sv ----
// Purpose: types of the motion command state arbiter
// Assumes: nothing
// Notes:   gray codes follow the usual motion path
package mcsa_pkg;
  typedef enum logic [3:0] {
    MCSA_STANDBY   = 4'h0,
    MCSA_STOPPED   = 4'h1,
    MCSA_MOVING    = 4'h3,
    MCSA_TWO_STEP  = 4'h2,
    MCSA_DECEL     = 4'h6,
    MCSA_FHALT     = 4'h7,
    MCSA_DHALTED   = 4'h5,
    MCSA_SHUTDOWN  = 4'h4,
    MCSA_SLEEP     = 4'hc,
    MCSA_LS_HALT   = 4'hd,
    MCSA_LS_OFF    = 4'hf
  } mcsa_state_t;

  typedef struct packed {
    logic [3:0]  code;
    logic [15:0] data;
  } mcsa_cmd_t;
endpackage : mcsa_pkg

// ---- test/mcsa_master_model.sv ----
// Purpose: register bus master standing in for the remote bus master
// Assumes: slave answers with waitrequest low at some edge
// Notes:   each wait is bounded; ok stays low when it runs out
`timescale 1ns/10ps
`default_nettype none
module mcsa_master_model (
  // clock
  input  wire logic        ref_clk,
  // avalon-mm master side
  output var logic  [4:0]  avs_address,
  output var logic         avs_read,
  output var logic         avs_write,
  output var logic  [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial
  begin
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
  end

  // ----
  // one access
  // ----
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q  = 32'h0000_0000;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge ref_clk);
      ok = (avs_waitrequest === 1'b0);
      q  = avs_readdata;
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : xfer
endmodule : mcsa_master_model
`default_nettype wire

// ---- test/motion_command_state_arbiter_bench.sv ----
// Purpose: self-checking bench of the motion command state arbiter
// Assumes: state rows reached by forcing through ext_state_valid
// Notes:   byteenable held constant
`timescale 1ns/10ps
`default_nettype none
`include "mcsa_cfg.svh"
module motion_command_state_arbiter_bench;
  logic                  ref_clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic [3:0]            ev = 4'h0;
  logic                  dn = 1'b0;
  logic                  en = 1'b1;
  mcsa_pkg::mcsa_state_t ext_state = mcsa_pkg::MCSA_STANDBY;
  logic [4:0]            avs_address;
  logic                  avs_read, avs_write, avs_waitrequest, sleep_flag;
  logic [31:0]           avs_writedata, avs_readdata, q;
  mcsa_pkg::mcsa_state_t motion_state;
  logic [15:0]           target_pos, actual_pos, motion_params, sec, v;
  int                    fail_count = 0;
  int                    samples_checked = 0;

  always #2.5 ref_clk = ~ref_clk;

  mcsa_master_model u_master (.ref_clk, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);

  mcsa_arbiter u_dut (.ref_clk, .sys_rst, .clk_en(en), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .bus_timeout(ev[0]), .motion_done(ev[1]), .step_pulse(ev[2]), .step_down(dn),
    .ext_state_valid(ev[3]), .ext_state, .motion_state, .target_pos, .actual_pos,
    .motion_params, .sleep_flag);

  // ----
  // helpers
  // ----
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // short target: 11-bit signed field, sign-extended to a full position
  function automatic logic [15:0] exp_short(input logic [15:0] d);
    return {{5{d[10]}}, d[10:0]};
  endfunction : exp_short

  task automatic cst(input mcsa_pkg::mcsa_state_t e);
    chk("state", {12'h000, e}, {12'h000, motion_state});
  endtask : cst

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    logic ok;
    u_master.xfer(w, a, d, q, ok);
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("unexpected waitrequest: expected 0 seen 1");
      summarize();
    end
  endtask : bus

  // effect lands on the completing edge; one spare edge follows
  task automatic cmd(input logic [3:0] c, input logic [15:0] d);
    bus(1'b1, `MCSA_OFF_CMD, {d, 12'h000, c});
    @(posedge ref_clk);
    #1;
  endtask : cmd

  // spare edge so registered outputs have settled
  task automatic pulse(input logic [3:0] b, input mcsa_pkg::mcsa_state_t s);
    @(posedge ref_clk);
    ev        <= b;
    ext_state <= s;
    @(posedge ref_clk);
    ev <= 4'h0;
    @(posedge ref_clk);
    #1;
  endtask : pulse

  task automatic rst();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask : rst

  // ----
  // main sequence
  // ----
  initial
  begin
    mcsa_pkg::mcsa_state_t all[10] = '{mcsa_pkg::MCSA_STANDBY, mcsa_pkg::MCSA_STOPPED,
      mcsa_pkg::MCSA_MOVING, mcsa_pkg::MCSA_TWO_STEP, mcsa_pkg::MCSA_DECEL,
      mcsa_pkg::MCSA_FHALT, mcsa_pkg::MCSA_DHALTED, mcsa_pkg::MCSA_SHUTDOWN,
      mcsa_pkg::MCSA_LS_HALT, mcsa_pkg::MCSA_LS_OFF};
    void'($urandom(32'hc4edd8ef));
    rst();
    cst(mcsa_pkg::MCSA_STANDBY);
    foreach (all[i])
    begin
      sec = 16'($urandom);
      pulse(4'h8, all[i]);
      cmd(`MCSA_CMD_LOAD, sec);
      chk("params", sec, motion_params);
    end
    pulse(4'h8, mcsa_pkg::MCSA_STOPPED);
    pulse(4'h4, mcsa_pkg::MCSA_STOPPED);
    @(posedge ref_clk);
    dn <= 1'b1;
    pulse(4'h4, mcsa_pkg::MCSA_STOPPED);
    pulse(4'h4, mcsa_pkg::MCSA_STOPPED);
    chk("actual", 16'hffff, actual_pos);
    cmd(`MCSA_CMD_CLEAR, 16'h0000);
    chk("actual", 16'h0000, actual_pos);
    cmd(`MCSA_CMD_SET_SH, 16'h07f0);
    chk("target", exp_short(16'h07f0), target_pos);
    cst(mcsa_pkg::MCSA_MOVING);
    sec = 16'($urandom);
    cmd(`MCSA_CMD_SET_SH, sec);
    chk("target", exp_short(sec), target_pos);
    sec = 16'($urandom);
    cmd(`MCSA_CMD_SET, sec);
    chk("target", sec, target_pos);
    repeat (3)
    begin
      sec = 16'($urandom);
      v   = 16'($urandom);
      pulse(4'h8, mcsa_pkg::MCSA_STOPPED);
      bus(1'b1, `MCSA_OFF_SEC_POS, {16'h0000, sec});
      bus(1'b1, `MCSA_OFF_CTRL, 32'h0000_0001);
      cmd(`MCSA_CMD_GOSEC, 16'h0000);
      chk("target", sec, target_pos);
      cst(mcsa_pkg::MCSA_MOVING);
      bus(1'b1, `MCSA_OFF_SEC_POS, {16'h0000, v});
      bus(1'b1, `MCSA_OFF_CTRL, 32'h0000_0000);
      cmd(`MCSA_CMD_GOSEC, 16'h0000);
      chk("target", sec, target_pos);
      bus(1'b1, `MCSA_OFF_CTRL, 32'h0000_0001);
      cmd(`MCSA_CMD_GOSEC, 16'h0000);
      chk("target", v, target_pos);
      cst(mcsa_pkg::MCSA_MOVING);
    end
    sec = 16'($urandom);
    bus(1'b1, `MCSA_OFF_SEC_POS, {16'h0000, sec});
    pulse(4'h1, mcsa_pkg::MCSA_MOVING);
    chk("target", sec, target_pos);
    chk("sleep", 16'h0001, {15'h0000, sleep_flag});
    cmd(`MCSA_CMD_LOAD, sec);
    chk("sleep", 16'h0000, {15'h0000, sleep_flag});
    bus(1'b1, `MCSA_OFF_CTRL, 32'h0000_0000);
    pulse(4'h1, mcsa_pkg::MCSA_MOVING);
    cst(mcsa_pkg::MCSA_DECEL);
    pulse(4'h1, mcsa_pkg::MCSA_MOVING);
    cst(mcsa_pkg::MCSA_DECEL);
    pulse(4'h2, mcsa_pkg::MCSA_MOVING);
    cst(mcsa_pkg::MCSA_SLEEP);
    rst();
    pulse(4'h8, mcsa_pkg::MCSA_STOPPED);
    cmd(`MCSA_CMD_TWO, 16'h0000);
    sec = 16'($urandom);
    bus(1'b1, `MCSA_OFF_SEC_POS, {16'h0000, sec});
    bus(1'b1, `MCSA_OFF_CTRL, 32'h0000_0001);
    cmd(`MCSA_CMD_SLEEP, 16'h0000);
    chk("target", sec, target_pos);
    cst(mcsa_pkg::MCSA_TWO_STEP);
    pulse(4'h2, mcsa_pkg::MCSA_MOVING);
    cst(mcsa_pkg::MCSA_SLEEP);
    rst();
    for (int i = 5; i < 10; i++)
    begin
      if (i == 7)
        continue;
      pulse(4'h8, all[i]);
      pulse(4'h1, all[i]);
      cst(all[i]);
      chk("sleep", 16'h0001, {15'h0000, sleep_flag});
    end
    pulse(4'h8, mcsa_pkg::MCSA_STANDBY);
    cmd(`MCSA_CMD_SLEEP, 16'h0000);
    cst(mcsa_pkg::MCSA_SLEEP);
    bus(1'b0, `MCSA_OFF_STATUS, 32'h0000_0000);
    chk("status", 16'h001c, q[15:0]);
    v = motion_params;
    cmd(`MCSA_CMD_LOAD, ~v);
    chk("params", v, motion_params);
    bus(1'b0, `MCSA_OFF_STATUS, 32'h0000_0000);
    chk("status", 16'h000c, q[15:0]);
    bus(1'b0, 5'h1c, 32'h0000_0000);
    chk("unmapped", 16'h0000, q[15:0]);
    rst();
    // clock enable low: a timeout must leave every flop alone
    @(posedge ref_clk);
    en <= 1'b0;
    pulse(4'h1, mcsa_pkg::MCSA_STANDBY);
    cst(mcsa_pkg::MCSA_STANDBY);
    chk("sleep", 16'h0000, {15'h0000, sleep_flag});
    @(posedge ref_clk);
    en <= 1'b1;
    pulse(4'h1, mcsa_pkg::MCSA_STANDBY);
    cst(mcsa_pkg::MCSA_SLEEP);
    summarize();
  end
endmodule : motion_command_state_arbiter_bench
`default_nettype wire

// ---- verilog/mcsa_arbiter.sv ----
// Purpose: decides how bus commands act in each motion state
// Assumes: commands arrive as writes to the command register
// Notes:   other state events enter through bus_timeout, motion_done, step_pulse and ext_state_valid
//
// Operation
// R1: load params in every state but sleep
// R2: stopped go-secondary with enable: target, move
// R3: moving/two-step go-secondary: target only, enable needed
// R4: standby plus sleep or timeout enters sleep
// R5: sleep/timeout sets flag; later command clears
// R6: moving sleep: secondary target, else decelerate
// R7: two-step sleep: secondary target, flag later
// R8: decelerating: sleep waits until motor stops
// R9: halt, shutdown states: sleep waits likewise (code: only forced halt acts at the stop; others keep the flag only)
// R10: set-target and clear-position per state
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "mcsa_cfg.svh"

module mcsa_arbiter (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  // avalon-mm slave
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // state manager events
  input  wire logic                  bus_timeout,
  input  wire logic                  motion_done,
  input  wire logic                  step_pulse,
  input  wire logic                  step_down,
  input  wire logic                  ext_state_valid,
  input  wire mcsa_pkg::mcsa_state_t ext_state,
  // state, positions and parameters
  output mcsa_pkg::mcsa_state_t      motion_state,
  output logic      [15:0]           target_pos,
  output logic      [15:0]           actual_pos,
  output logic      [15:0]           motion_params,
  output logic                       sleep_flag
);

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic        wait_r,   wait_nxt;
  logic [31:0] rdata_r,  rdata_nxt;
  logic        sec_en_r, sec_en_nxt;
  logic [15:0] sec_r,    sec_nxt;
  logic [31:0] be_mask;
  logic        wr_acc;
  logic        cmd_go;
  mcsa_pkg::mcsa_cmd_t cmd;

  mcsa_pkg::mcsa_state_t st_r, st_nxt;
  logic [15:0] tgt_r, tgt_nxt;
  logic [15:0] act_r, act_nxt;
  logic [15:0] par_r, par_nxt;
  logic        slp_r, slp_nxt;
  logic        sleep_req;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_be
      assign be_mask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  // one wait cycle, then the access completes with waitrequest low
  assign wr_acc = avs_write & ~wait_r;
  assign cmd_go = wr_acc & (avs_address == `MCSA_OFF_CMD);
  assign cmd    = '{code: avs_writedata[`MCSA_F_CODE], data: avs_writedata[`MCSA_F_DATA]};

  always_comb
  begin
    logic [31:0] merged;
    merged     = `MCSA_WORD_ZERO;
    wait_nxt   = 1'b1;
    rdata_nxt  = rdata_r;
    sec_en_nxt = sec_en_r;
    sec_nxt    = sec_r;
    if ((avs_read | avs_write) & wait_r)
    begin
      wait_nxt  = 1'b0;
      rdata_nxt = `MCSA_WORD_ZERO;
      if (avs_read)
      begin
        unique case (avs_address)
          `MCSA_OFF_CTRL:    rdata_nxt[`MCSA_F_SEC_EN] = sec_en_r;
          `MCSA_OFF_SEC_POS: rdata_nxt[`MCSA_F_POS]    = sec_r;
          `MCSA_OFF_STATUS:
          begin
            rdata_nxt[`MCSA_F_STATE] = st_r;
            rdata_nxt[`MCSA_F_SLEEP] = slp_r;
          end
          `MCSA_OFF_TARGET:  rdata_nxt[`MCSA_F_POS]    = tgt_r;
          `MCSA_OFF_ACTUAL:  rdata_nxt[`MCSA_F_POS]    = act_r;
          `MCSA_OFF_PARAM:   rdata_nxt[`MCSA_F_POS]    = par_r;
          default:           rdata_nxt = `MCSA_WORD_ZERO;
        endcase
      end
    end
    if (wr_acc)
    begin
      if (avs_address == `MCSA_OFF_CTRL)
      begin
        merged     = ({31'h0000_0000, sec_en_r} & ~be_mask) | (avs_writedata & be_mask);
        sec_en_nxt = merged[`MCSA_F_SEC_EN];
      end
      if (avs_address == `MCSA_OFF_SEC_POS)
      begin
        merged  = ({16'h0000, sec_r} & ~be_mask) | (avs_writedata & be_mask);
        sec_nxt = merged[`MCSA_F_POS];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wait_r   <= 1'b1;
      rdata_r  <= `MCSA_WORD_ZERO;
      sec_en_r <= 1'b0;
      sec_r    <= `MCSA_POS_RST;
    end
    else if (clk_en)
    begin
      wait_r   <= wait_nxt;
      rdata_r  <= rdata_nxt;
      sec_en_r <= sec_en_nxt;
      sec_r    <= sec_nxt;
    end
  end

  // ----------------------------------------
  // command arbitration
  // ----------------------------------------
  assign sleep_req = (cmd_go & (cmd.code == `MCSA_CMD_SLEEP)) | bus_timeout;

  always_comb
  begin
    st_nxt  = st_r;
    tgt_nxt = tgt_r;
    act_nxt = act_r;
    par_nxt = par_r;
    slp_nxt = slp_r;
    if (step_pulse)
      act_nxt = step_down ? act_r - `MCSA_POS_ONE : act_r + `MCSA_POS_ONE;
    // the set beats a clear arriving in the same cycle
    if (cmd_go & (cmd.code != `MCSA_CMD_SLEEP))
      slp_nxt = 1'b0; // [R5]
    if (sleep_req)
      slp_nxt = 1'b1; // [R5]
    if (cmd_go)
    begin
      unique case (cmd.code)
        `MCSA_CMD_LOAD:
          if (st_r != mcsa_pkg::MCSA_SLEEP)
            par_nxt = cmd.data; // [R1]
        `MCSA_CMD_CLEAR:
          if (st_r == mcsa_pkg::MCSA_STOPPED || st_r == mcsa_pkg::MCSA_SHUTDOWN ||
              st_r == mcsa_pkg::MCSA_LS_OFF)
          begin
            tgt_nxt = `MCSA_POS_RST; // [R10]
            act_nxt = `MCSA_POS_RST; // [R10]
          end
        `MCSA_CMD_SET, `MCSA_CMD_SET_SH:
        begin
          if (st_r == mcsa_pkg::MCSA_STOPPED || st_r == mcsa_pkg::MCSA_MOVING ||
              st_r == mcsa_pkg::MCSA_TWO_STEP)
            tgt_nxt = (cmd.code == `MCSA_CMD_SET) ? cmd.data
                    : 16'($signed(avs_writedata[`MCSA_F_SHORT])); // [R10]
          if (st_r == mcsa_pkg::MCSA_STOPPED)
            st_nxt = mcsa_pkg::MCSA_MOVING; // [R10]
        end
        `MCSA_CMD_GOSEC:
          if (sec_en_r)
          begin
            if (st_r == mcsa_pkg::MCSA_STOPPED)
            begin
              tgt_nxt = sec_r; // [R2]
              st_nxt  = mcsa_pkg::MCSA_MOVING; // [R2]
            end
            else if (st_r == mcsa_pkg::MCSA_MOVING || st_r == mcsa_pkg::MCSA_TWO_STEP)
              tgt_nxt = sec_r; // [R3]
          end
        `MCSA_CMD_TWO:
          if (st_r == mcsa_pkg::MCSA_STOPPED)
            st_nxt = mcsa_pkg::MCSA_TWO_STEP;
        `MCSA_CMD_DECEL:
          if (st_r == mcsa_pkg::MCSA_MOVING)
            st_nxt = mcsa_pkg::MCSA_DECEL;
        default:
          st_nxt = st_r;
      endcase
    end
    // decel and halt states leave the flag; only decel and forced halt act on it at the stop
    if (sleep_req)
    begin
      if (st_r == mcsa_pkg::MCSA_STANDBY)
        st_nxt = mcsa_pkg::MCSA_SLEEP; // [R4]
      else if (st_r == mcsa_pkg::MCSA_MOVING)
      begin
        if (sec_en_r)
          tgt_nxt = sec_r; // [R6]
        else
          st_nxt = mcsa_pkg::MCSA_DECEL; // [R6]
      end
      else if (st_r == mcsa_pkg::MCSA_TWO_STEP && sec_en_r)
        tgt_nxt = sec_r; // [R7]
    end
    if (motion_done)
    begin
      if (st_r == mcsa_pkg::MCSA_MOVING || st_r == mcsa_pkg::MCSA_TWO_STEP)
        st_nxt = slp_r ? mcsa_pkg::MCSA_SLEEP : mcsa_pkg::MCSA_STOPPED; // [R7]
      else if (st_r == mcsa_pkg::MCSA_DECEL || st_r == mcsa_pkg::MCSA_FHALT)
      begin
        tgt_nxt = act_r;
        st_nxt  = slp_r ? mcsa_pkg::MCSA_SLEEP : mcsa_pkg::MCSA_STOPPED; // [R8] [R9]
      end
    end
    // sleep is left only through reset
    if (ext_state_valid && st_r != mcsa_pkg::MCSA_SLEEP)
      st_nxt = ext_state;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_r  <= mcsa_pkg::MCSA_STANDBY;
      tgt_r <= `MCSA_POS_RST;
      act_r <= `MCSA_POS_RST;
      par_r <= `MCSA_PAR_RST;
      slp_r <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r  <= st_nxt;
      tgt_r <= tgt_nxt;
      act_r <= act_nxt;
      par_r <= par_nxt;
      slp_r <= slp_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign motion_state    = st_r;
  assign target_pos      = tgt_r;
  assign actual_pos      = act_r;
  assign motion_params   = par_r;
  assign sleep_flag      = slp_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic quiet;
  assign quiet = clk_en & ~ext_state_valid & ~motion_done;

  sequence s_cmd(logic [3:0] c);
    cmd_go && cmd.code == c && quiet;
  endsequence

  sequence s_req_wait;
    (avs_read || avs_write) && wait_r && clk_en;
  endsequence

  AST_BUS_ANSWER: assert property (s_req_wait |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus access not answered after one wait cycle");

  AST_PARAM_LOAD: assert property ( // [R1]
    s_cmd(`MCSA_CMD_LOAD) and (st_r != mcsa_pkg::MCSA_SLEEP) |=> motion_params == $past(cmd.data))
    else $error("parameter load not stored");

  AST_GOSEC_STOP: assert property ( // [R2]
    s_cmd(`MCSA_CMD_GOSEC) and (st_r == mcsa_pkg::MCSA_STOPPED && sec_en_r)
    |=> motion_state == mcsa_pkg::MCSA_MOVING && target_pos == $past(sec_r))
    else $error("go-secondary from stopped failed");

  AST_GOSEC_OFF: assert property ( // [R3]
    s_cmd(`MCSA_CMD_GOSEC) and (!sec_en_r && !bus_timeout &&
    (st_r == mcsa_pkg::MCSA_MOVING || st_r == mcsa_pkg::MCSA_TWO_STEP))
    |=> $stable(target_pos) && $stable(motion_state))
    else $error("disabled go-secondary changed target");

  AST_STANDBY_SLEEP: assert property ( // [R4]
    sleep_req && st_r == mcsa_pkg::MCSA_STANDBY && quiet |=> motion_state == mcsa_pkg::MCSA_SLEEP)
    else $error("standby did not enter sleep");

  AST_SLEEP_FLAG: assert property ( // [R5]
    sleep_req && clk_en |=> sleep_flag)
    else $error("sleep flag not set");

  AST_MOVE_SLEEP: assert property ( // [R6]
    sleep_req && st_r == mcsa_pkg::MCSA_MOVING && !sec_en_r && quiet && !cmd_go
    |=> motion_state == mcsa_pkg::MCSA_DECEL)
    else $error("moving sleep did not decelerate");

  AST_TWO_SLEEP: assert property ( // [R7]
    sleep_req && st_r == mcsa_pkg::MCSA_TWO_STEP && sec_en_r && quiet &&
    (!cmd_go || cmd.code == `MCSA_CMD_SLEEP)
    |=> target_pos == $past(sec_r) && motion_state == mcsa_pkg::MCSA_TWO_STEP)
    else $error("two-step sleep handling wrong");

  AST_DECEL_WAIT: assert property ( // [R8]
    bus_timeout && st_r == mcsa_pkg::MCSA_DECEL && quiet && !cmd_go
    |=> motion_state == mcsa_pkg::MCSA_DECEL && $stable(target_pos))
    else $error("decelerating state acted on sleep");

  AST_HALT_WAIT: assert property ( // [R9]
    bus_timeout && quiet && !cmd_go && (st_r == mcsa_pkg::MCSA_FHALT || st_r == mcsa_pkg::MCSA_DHALTED ||
    st_r == mcsa_pkg::MCSA_SHUTDOWN || st_r == mcsa_pkg::MCSA_LS_HALT) |=> $stable(motion_state))
    else $error("halt state acted on sleep");

  AST_CLEAR_POS: assert property ( // [R10]
    s_cmd(`MCSA_CMD_CLEAR) and (st_r == mcsa_pkg::MCSA_STOPPED || st_r == mcsa_pkg::MCSA_SHUTDOWN)
    |=> target_pos == `MCSA_POS_RST && actual_pos == `MCSA_POS_RST)
    else $error("clear position failed");

endmodule : mcsa_arbiter
`default_nettype wire
